/* File: pkg/mmpb_pkg.sv */
// shared constants and types for the master write / pipelined read port pair
package mmpb_pkg;
  localparam int MMPB_AW = 32;
  localparam int MMPB_DW = 32;
  localparam int MMPB_BW = MMPB_DW / 8;
  localparam int MMPB_LAT = 2;
  localparam int MMPB_MEM_WORDS = 16;
  localparam int MMPB_IDX_W = 4;
  localparam int MMPB_IDX_LSB = 2;
  localparam int MMPB_WAIT = 1;
  localparam logic [MMPB_BW-1:0] MMPB_BE_ALL = 4'hf;
  localparam logic [MMPB_BW-1:0] MMPB_BE_NONE = 4'h0;
  localparam logic [MMPB_AW-1:0] MMPB_ADDR_RST = 32'h0000_0000;
  localparam logic [MMPB_DW-1:0] MMPB_DATA_RST = 32'h0000_0000;
  localparam logic [1:0] MMPB_WCNT_RST = 2'h0;
  typedef enum logic {MMPB_W_IDLE, MMPB_W_BUSY} mmpb_wstate_t;
endpackage : mmpb_pkg

/* File: pkg/mmpb_if.sv */
// bus interface joining the master/slave port and the fabric end
`timescale 1ns/1ps
interface mmpb_if;
  logic [mmpb_pkg::MMPB_AW-1:0] m_address;
  logic [mmpb_pkg::MMPB_BW-1:0] m_byteenable;
  logic [mmpb_pkg::MMPB_DW-1:0] m_writedata;
  logic m_write;
  logic m_read;
  logic m_waitrequest;
  logic [mmpb_pkg::MMPB_AW-1:0] s_address;
  logic s_chipselect;
  logic s_read;
  logic [mmpb_pkg::MMPB_DW-1:0] s_readdata;
  logic s_waitrequest;
  modport dev (
    output m_address, m_byteenable, m_writedata, m_write, m_read,
    input m_waitrequest,
    input s_address, s_chipselect, s_read,
    output s_readdata, s_waitrequest
  );
  modport fab (
    input m_address, m_byteenable, m_writedata, m_write, m_read,
    output m_waitrequest,
    output s_address, s_chipselect, s_read,
    input s_readdata, s_waitrequest
  );
endinterface : mmpb_if

/* File: src/mmpb_dev.sv */
// device end: write master port and fixed-latency pipelined read slave
`timescale 1ns/1ps
module mmpb_dev (
  input wire logic sys_clk,
  input wire logic rst,
  mmpb_if.dev bus,
  input wire logic wr_req,
  input wire logic [mmpb_pkg::MMPB_AW-1:0] wr_addr,
  input wire logic [mmpb_pkg::MMPB_BW-1:0] wr_be,
  input wire logic [mmpb_pkg::MMPB_DW-1:0] wr_data,
  output logic wr_ready,
  output logic wr_done,
  output logic wr_be_bad
);
  mmpb_pkg::mmpb_wstate_t wstate_r;
  logic [mmpb_pkg::MMPB_AW-1:0] addr_r;
  logic [mmpb_pkg::MMPB_BW-1:0] be_r;
  logic [mmpb_pkg::MMPB_DW-1:0] wdata_r;
  logic write_r;
  logic done_r;
  logic bad_r;
  logic ready_r;
  logic be_legal;
  logic take;
  logic finish;
  logic [mmpb_pkg::MMPB_DW-1:0] mem_r [mmpb_pkg::MMPB_MEM_WORDS];
  logic [mmpb_pkg::MMPB_LAT-1:0] vld_r;
  logic [mmpb_pkg::MMPB_DW-1:0] pipe_r [mmpb_pkg::MMPB_LAT];
  logic [1:0] wcnt_r;
  logic swait_r;
  logic accept;
  logic [mmpb_pkg::MMPB_IDX_W-1:0] ridx;

  // byte-lane mask legality: contiguous, power of two, self aligned
  always_comb begin
    unique case (wr_be)
      4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf: be_legal = 1'b1;
      default: be_legal = 1'b0;
    endcase
  end

  assign take = (wstate_r == mmpb_pkg::MMPB_W_IDLE) && wr_req && be_legal;
  assign finish = (wstate_r == mmpb_pkg::MMPB_W_BUSY) && !bus.m_waitrequest;

  // write master state: one write at a time, never overlapped
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wstate_r <= mmpb_pkg::MMPB_W_IDLE;
    end else if (finish) begin
      wstate_r <= mmpb_pkg::MMPB_W_IDLE;
    end else if (take) begin
      wstate_r <= mmpb_pkg::MMPB_W_BUSY;
    end
  end

  // write outputs: launched on start edge, frozen while stalled
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_r <= mmpb_pkg::MMPB_ADDR_RST;
      be_r <= mmpb_pkg::MMPB_BE_NONE;
      wdata_r <= mmpb_pkg::MMPB_DATA_RST;
      write_r <= 1'b0;
    end else if (take) begin
      addr_r <= {wr_addr[mmpb_pkg::MMPB_AW-1:mmpb_pkg::MMPB_IDX_LSB],
                 2'h0};
      be_r <= wr_be;
      wdata_r <= wr_data;
      write_r <= 1'b1;
    end else if (finish) begin
      addr_r <= mmpb_pkg::MMPB_ADDR_RST;
      be_r <= mmpb_pkg::MMPB_BE_NONE;
      wdata_r <= mmpb_pkg::MMPB_DATA_RST;
      write_r <= 1'b0;
    end
    // stalled: nothing changes
  end

  // user-side status flags
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      done_r <= 1'b0;
      bad_r <= 1'b0;
    end else begin
      done_r <= finish;
      bad_r <= (wstate_r == mmpb_pkg::MMPB_W_IDLE) && wr_req && !be_legal;
    end
  end

  // user-side ready: mirrors the idle state in its own flop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ready_r <= 1'b1;
    end else if (finish) begin
      ready_r <= 1'b1;
    end else if (take) begin
      ready_r <= 1'b0;
    end
  end

  assign bus.m_address = addr_r;
  assign bus.m_byteenable = be_r;
  assign bus.m_writedata = wdata_r;
  assign bus.m_write = write_r;
  assign bus.m_read = 1'b0;
  assign wr_ready = ready_r;
  assign wr_done = done_r;
  assign wr_be_bad = bad_r;

  // slave wait-state counter: one wait per read, address phase only
  // swait_r high means the waits are spent and the address is taken now
  assign accept = bus.s_chipselect && bus.s_read && swait_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wcnt_r <= mmpb_pkg::MMPB_WCNT_RST;
      swait_r <= 1'b0;
    end else if (accept) begin
      // next read must pay its own wait-state again
      wcnt_r <= mmpb_pkg::MMPB_WCNT_RST;
      swait_r <= 1'b0;
    end else if (bus.s_chipselect && bus.s_read) begin
      wcnt_r <= wcnt_r + 2'h1;
      swait_r <= (wcnt_r + 2'h1) >= 2'(mmpb_pkg::MMPB_WAIT);
    end else begin
      wcnt_r <= mmpb_pkg::MMPB_WCNT_RST;
      swait_r <= 1'b0;
    end
  end

  assign ridx = bus.s_address[mmpb_pkg::MMPB_IDX_LSB +: mmpb_pkg::MMPB_IDX_W];

  // read pipeline: stage per latency cycle, at most one read in flight since the wait-state spaces accepts two cycles apart
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      vld_r <= '0;
    end else begin
      vld_r <= {vld_r[mmpb_pkg::MMPB_LAT-2:0], accept};
    end
  end

  // data stages: stage 0 loads the store word when the address is taken,
  // later stages pass it on with their valid flag, zero otherwise, so the
  // last stage holds a word only in its own data-phase slot
  generate
    for (genvar s = 0; s < mmpb_pkg::MMPB_LAT; s++) begin : g_pipe
      if (s == 0) begin : g_load
        always_ff @(posedge sys_clk or posedge rst) begin
          if (rst) begin
            pipe_r[s] <= mmpb_pkg::MMPB_DATA_RST;
          end else begin
            pipe_r[s] <= accept ? mem_r[ridx] : mmpb_pkg::MMPB_DATA_RST;
          end
        end
      end else begin : g_shift
        always_ff @(posedge sys_clk or posedge rst) begin
          if (rst) begin
            pipe_r[s] <= mmpb_pkg::MMPB_DATA_RST;
          end else begin
            pipe_r[s] <= vld_r[s-1] ? pipe_r[s-1] : mmpb_pkg::MMPB_DATA_RST;
          end
        end
      end
    end
  endgenerate

  // backing store written by this port's own writes, byte lanes honoured
  generate
    for (genvar w = 0; w < mmpb_pkg::MMPB_MEM_WORDS; w++) begin : g_mem
      for (genvar b = 0; b < mmpb_pkg::MMPB_BW; b++) begin : g_lane
        always_ff @(posedge sys_clk or posedge rst) begin
          if (rst) begin
            mem_r[w][b*8 +: 8] <= 8'h00;
          end else if (finish && be_r[b] &&
                       addr_r[mmpb_pkg::MMPB_IDX_LSB +: mmpb_pkg::MMPB_IDX_W] == w) begin
            mem_r[w][b*8 +: 8] <= wdata_r[b*8 +: 8];
          end
        end
      end
    end
  endgenerate

  // word shows only in the data phase's last cycle, sampled on edge N
  // straight from the last stage flop, zero outside its slot
  assign bus.s_readdata = pipe_r[mmpb_pkg::MMPB_LAT-1];
  assign bus.s_waitrequest = bus.s_chipselect && bus.s_read && !swait_r;
endmodule : mmpb_dev

/* File: src/mmpb_fab.sv */
// fabric end: stalls master writes, issues pipelined reads to the slave
`timescale 1ns/1ps
module mmpb_fab (
  input wire logic sys_clk,
  input wire logic rst,
  mmpb_if.fab bus,
  input wire logic [3:0] stall_cnt,
  input wire logic rd_req,
  input wire logic [mmpb_pkg::MMPB_AW-1:0] rd_addr,
  output logic rd_ready,
  output logic rd_valid,
  output logic [mmpb_pkg::MMPB_DW-1:0] rd_data,
  output logic [mmpb_pkg::MMPB_DW-1:0] wr_seen_data,
  output logic wr_seen
);
  logic [3:0] scnt_r;
  logic busy_r;
  logic wreq_r;
  logic cs_r;
  logic [mmpb_pkg::MMPB_AW-1:0] raddr_r;
  logic [mmpb_pkg::MMPB_LAT:0] inflt_r;
  logic rvalid_r;
  logic [mmpb_pkg::MMPB_DW-1:0] rdata_r;
  logic wseen_r;
  logic [mmpb_pkg::MMPB_DW-1:0] wsd_r;
  logic wdone;

  // stall generator: wait-states only during a write, low otherwise
  assign wdone = bus.m_write && busy_r && (scnt_r == 4'h0);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      scnt_r <= 4'h0;
    end else if (bus.m_write && !busy_r) begin
      busy_r <= (stall_cnt != 4'h0);
      scnt_r <= (stall_cnt == 4'h0) ? 4'h0 : stall_cnt - 4'h1;
    end else if (wdone) begin
      busy_r <= 1'b0;
    end else if (busy_r && scnt_r != 4'h0) begin
      scnt_r <= scnt_r - 4'h1;
    end
  end
  always_comb begin
    wreq_r = 1'b0;
    if (bus.m_write && !busy_r) begin
      wreq_r = (stall_cnt != 4'h0);
    end else if (busy_r) begin
      wreq_r = (scnt_r != 4'h0);
    end
  end
  assign bus.m_waitrequest = wreq_r;

  // record completed writes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wseen_r <= 1'b0;
      wsd_r <= mmpb_pkg::MMPB_DATA_RST;
    end else begin
      wseen_r <= bus.m_write && !wreq_r;
      if (bus.m_write && !wreq_r) begin
        wsd_r <= bus.m_writedata;
      end
    end
  end

  // read issue: hold select, strobe, address while slave stalls
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cs_r <= 1'b0;
      raddr_r <= mmpb_pkg::MMPB_ADDR_RST;
    end else if (!(cs_r && bus.s_waitrequest)) begin
      cs_r <= rd_req;
      raddr_r <= rd_addr;
    end
  end
  assign bus.s_chipselect = cs_r;
  assign bus.s_read = cs_r;
  assign bus.s_address = raddr_r;
  assign rd_ready = !(cs_r && bus.s_waitrequest);

  // capture each word exactly latency edges after address phase ends
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      inflt_r <= '0;
      rvalid_r <= 1'b0;
      rdata_r <= mmpb_pkg::MMPB_DATA_RST;
    end else begin
      inflt_r <= {inflt_r[mmpb_pkg::MMPB_LAT-1:0], cs_r && !bus.s_waitrequest};
      rvalid_r <= inflt_r[mmpb_pkg::MMPB_LAT-1];
      if (inflt_r[mmpb_pkg::MMPB_LAT-1]) begin
        rdata_r <= bus.s_readdata;
      end
    end
  end
  assign rd_valid = rvalid_r;
  assign rd_data = rdata_r;
  assign wr_seen = wseen_r;
  assign wr_seen_data = wsd_r;
endmodule : mmpb_fab

/* File: bench/mmpb_sva.sv */
// assertions on the bus between the device and fabric ends
`timescale 1ns/1ps
module mmpb_sva (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [31:0] m_address,
  input wire logic [3:0] m_byteenable,
  input wire logic [31:0] m_writedata,
  input wire logic m_write,
  input wire logic m_read,
  input wire logic m_waitrequest,
  input wire logic [31:0] s_address,
  input wire logic s_chipselect,
  input wire logic s_read,
  input wire logic [31:0] s_readdata,
  input wire logic s_waitrequest
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // read address accepted by the slave
  logic rd_acc;
  assign rd_acc = s_chipselect && s_read && !s_waitrequest;
  chk_write_hold:
    assert property (m_write && m_waitrequest |=> m_write && $stable(m_address)
      && $stable(m_writedata) && $stable(m_byteenable)) else $error("write moved in stall");
  chk_write_end:
    assert property (m_write && !m_waitrequest |=> !m_write) else $error("write not released");
  chk_strobe_reset:
    assert property ($fell(rst) |-> !m_write && !m_read) else $error("strobe out of reset");
  chk_lanes_legal:
    assert property (m_write |-> m_byteenable inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc,
      4'hf}) else $error("illegal lane mask");
  chk_idle_nostall:
    assert property (!m_write |-> !m_waitrequest) else $error("stall while idle");
  chk_read_hold:
    assert property (s_chipselect && s_read && s_waitrequest |=> s_chipselect && s_read
      && $stable(s_address)) else $error("read moved in stall");
  chk_one_wait:
    assert property (s_waitrequest |=> !s_waitrequest) else $error("extra wait-state");
  chk_new_wait:
    assert property (rd_acc |=> !(s_chipselect && s_read) || s_waitrequest)
      else $error("read without wait-state");
  chk_data_slot:
    assert property (s_readdata != 32'h0 |-> $past(rd_acc, 2)) else $error("word off slot");
  // main scenarios
  cover property (m_write && m_waitrequest ##1 m_write && !m_waitrequest);
  cover property ($rose(m_write) && !m_waitrequest);
  cover property (rd_acc ##2 rd_acc);
endmodule : mmpb_sva

/* File: bench/tb_top.sv */
// self-checking bench joining the device and fabric ends
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wr_req = 1'b0;
  logic [31:0] wr_addr = 32'h0;
  logic [3:0] wr_be = 4'h0;
  logic [31:0] wr_data = 32'h0;
  logic [3:0] stall_cnt = 4'h0;
  logic rd_req = 1'b0;
  logic [31:0] rd_addr = 32'h0;
  logic wr_ready, wr_done, wr_be_bad, rd_ready, rd_valid;
  logic [31:0] rd_data;
  logic wr_seen;
  logic [31:0] wr_seen_data;
  logic [31:0] shadow [16];
  logic [3:0] lanes [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc};
  logic [3:0] junk [5] = '{4'h0, 4'h5, 4'h7, 4'h9, 4'he};
  int fails = 0;
  int checked = 0;
  mmpb_if bus_if ();
  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;
  mmpb_dev mmpb_dev_inst (.sys_clk(sys_clk), .rst(rst), .bus(bus_if), .wr_req(wr_req),
    .wr_addr(wr_addr), .wr_be(wr_be), .wr_data(wr_data), .wr_ready(wr_ready),
    .wr_done(wr_done), .wr_be_bad(wr_be_bad));
  mmpb_fab mmpb_fab_inst (.sys_clk(sys_clk), .rst(rst), .bus(bus_if), .stall_cnt(stall_cnt),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_ready(rd_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .wr_seen_data(wr_seen_data), .wr_seen(wr_seen));
  mmpb_sva mmpb_sva_inst (.sys_clk(sys_clk), .rst(rst), .m_address(bus_if.m_address),
    .m_byteenable(bus_if.m_byteenable), .m_writedata(bus_if.m_writedata),
    .m_write(bus_if.m_write), .m_read(bus_if.m_read), .m_waitrequest(bus_if.m_waitrequest),
    .s_address(bus_if.s_address), .s_chipselect(bus_if.s_chipselect), .s_read(bus_if.s_read),
    .s_readdata(bus_if.s_readdata), .s_waitrequest(bus_if.s_waitrequest));
  // verdict and end of run
  task automatic wrap_up();
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  // word compare
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t data %h exp %h", $time, got, exp);
    end
  endtask : chk_data
  // count compare
  task automatic chk_cnt(input int got, input int exp);
    checked++;
    if (got != exp) begin
      fails++;
      $display("MISMATCH t=%0t count %0d exp %0d", $time, got, exp);
    end
  endtask : chk_cnt
  // one write; exp is bus cycles, 0 for a refused mask
  task automatic wr(input logic [31:0] a, input logic [3:0] be, input logic [31:0] d,
      input logic [3:0] st, input int exp);
    int n;
    logic [3:0] seen;
    n = 0;
    seen = 4'h0;
    @(posedge sys_clk);
    wr_addr <= a;
    wr_be <= be;
    wr_data <= d;
    stall_cnt <= st;
    wr_req <= 1'b1;
    @(posedge sys_clk);
    wr_req <= 1'b0;
    repeat (40) begin
      #1;
      if (wr_done || wr_be_bad) break;
      if (bus_if.m_write) n++;
      if (bus_if.m_write) seen = bus_if.m_byteenable;
      @(posedge sys_clk);
    end
    chk_cnt(n, exp);
    if (exp == 0) chk_data({31'h0, wr_be_bad}, 32'h1);
    else chk_data({28'h0, seen}, {28'h0, be});
    chk_data({31'h0, wr_seen}, (exp > 0) ? 32'h1 : 32'h0);
    if (exp > 0) chk_data(wr_seen_data, d);
    chk_data({31'h0, wr_ready}, 32'h1);
    for (int i = 0; i < 4; i++) if (be[i] && exp > 0) shadow[a[5:2]][8*i+:8] = d[8*i+:8];
  endtask : wr
  // back-to-back reads of words 0..cnt-1
  task automatic rd_burst(input int cnt);
    logic ok;
    logic got;
    fork
      begin
        @(posedge sys_clk);
        for (int i = 0; i < cnt; i++) begin
          rd_addr <= 32'(i * 4);
          rd_req <= 1'b1;
          do begin
            #1;
            ok = rd_ready;
            @(posedge sys_clk);
          end while (!ok);
        end
        rd_req <= 1'b0;
      end
      for (int j = 0; j < cnt; j++) begin
        got = 1'b0;
        repeat (20) if (!got) begin
          @(posedge sys_clk);
          #1;
          got = rd_valid;
        end
        chk_data({31'h0, got}, 32'h1);
        chk_data(rd_data, shadow[j]);
      end
    join
  endtask : rd_burst
  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    wr(32'h0, 4'hf, 32'h1122_3344, 4'h0, 1);
    wr(32'h4, 4'hf, 32'h5566_7788, 4'h2, 3);
    wr(32'h8, 4'hf, 32'h99aa_bbcc, 4'hf, 16);
    foreach (lanes[i]) wr(32'h4, lanes[i], 32'h0102_0408 << i, 4'h1, 2);
    foreach (junk[i]) wr(32'h8, junk[i], 32'hdead_beef, 4'h0, 0);
    rd_burst(3);
    wrap_up();
  end
  // watchdog
  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    wrap_up();
  end
endmodule : tb_top
